// *** common/pwr_seq_pkg.sv ***
package pwr_seq_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_FEATURE  = 4'h1;
	localparam logic [3:0]  ADDR_REQUEST  = 4'h2;
	localparam logic [3:0]  ADDR_STATUS   = 4'h3;
	localparam logic [3:0]  ADDR_INFO     = 4'h4;
	localparam logic [3:0]  ADDR_ITC      = 4'h5;
	localparam logic [3:0]  ADDR_CYCLES   = 4'h6;
	localparam logic [3:0]  ADDR_TPR      = 4'h7;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int          CTRL_LP_EN_BIT   = 0;
	localparam int          FEAT_LP_SUP_BIT  = 0;
	localparam int          REQ_DEEP_BIT     = 3;
	localparam int          ST_ERR_BIT       = 8;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
	localparam logic [7:0]  TPR_RESET        = 8'h00;
	// implemented deep states (bit n = state n); bit 0 is the shallow stop
	localparam logic [7:0]  IMPL_STATES      = 8'h03;
	// coherency info per state: bit 2n cache coherent, bit 2n+1 tlb coherent
	localparam logic [15:0] COHERENCY_INFO   = 16'h0003;
	localparam logic        LP_SUPPORTED     = 1'b1;
	localparam logic [7:0]  WAKE_IMPL_CYCLES = 8'h04;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_NORMAL  = 3'b000,
		ST_LOWPWR  = 3'b001,
		ST_SHALLOW = 3'b011,
		ST_DEEP1   = 3'b010,
		ST_DEEPN   = 3'b110
	} pstate_t;

	typedef struct packed {
		logic       irq;
		logic [3:0] irq_class;
		logic       nmi;
		logic       mcheck;
		logic       soft_reset;
		logic       platform_mgmt_interrupt;
		logic       init;
	} wake_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic       wr;
		logic       rd;
	} regreq_t;

endpackage

// *** hw/wake_filter.sv ***
`timescale 1ns/100ps
module wake_filter (
	// event sources
	input  wire pwr_seq_pkg::wake_t events,
	input  wire logic [7:0]         tpr,
	// result
	output logic                    wake
);
	import pwr_seq_pkg::*;

	// mic masks classes at or below it; mmi masks every maskable one
	wire logic irq_ok = events.irq && !tpr[4] && (events.irq_class > tpr[3:0]);
	assign wake = irq_ok | events.nmi | events.mcheck | events.soft_reset
		| events.platform_mgmt_interrupt | events.init;
endmodule

// *** hw/free_counter.sv ***
`timescale 1ns/100ps
module free_counter (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        count_en,
	output logic [31:0]      value
);
	// plain up counter, held while count_en is low
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			value <= 32'h0000_0000;
		end else if (count_en) begin
			value <= value + 32'h0000_0001;
		end
	end
endmodule

// *** hw/power_state_sequencer.sv ***
`timescale 1ns/100ps
module power_state_sequencer (
	// clock and reset
	input  wire logic                 REF_CLK,
	input  wire logic                 RSTN,
	// register port
	input  wire pwr_seq_pkg::regreq_t REG_REQ,
	output logic [31:0]               REG_RDATA,
	// wake sources
	input  wire pwr_seq_pkg::wake_t   WAKE_EVENTS,
	// snoop traffic
	input  wire logic                 SNOOP_REQ,
	output logic                      SNOOP_ACK,
	// core control
	output logic                      CORE_RUN,
	output logic                      LOW_POWER_ACTIVE,
	output logic [2:0]                STATE
);
	import pwr_seq_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// both running codes execute code; every other code is a stop state
	function automatic logic is_running(input pstate_t s);
		return (s == ST_NORMAL) || (s == ST_LOWPWR);
	endfunction

	// a write strobe aimed at one register
	function automatic logic write_hit(input regreq_t r, input logic [3:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// ****************************************
	// state
	// ****************************************
	pstate_t     state;
	pstate_t     next_state;
	logic [2:0]  deep_arg;
	logic [2:0]  next_deep_arg;
	logic        lp_enable;
	logic [7:0]  tpr;
	logic        req_error;
	logic [31:0] itc_value;
	logic [31:0] cycle_value;
	logic [31:0] rdata;
	logic        wake;
	logic        soft_req_wake;

	// ****************************************
	// decode
	// ****************************************
	wire logic wr_ctrl  = write_hit(REG_REQ, ADDR_CTRL);
	wire logic wr_req   = write_hit(REG_REQ, ADDR_REQUEST);
	wire logic wr_tpr   = write_hit(REG_REQ, ADDR_TPR);
	wire logic [2:0] req_arg  = REG_REQ.wdata[2:0];
	wire logic       req_deep = REG_REQ.wdata[REQ_DEEP_BIT];
	// shallow stop is always present; deep requests check the map
	wire logic req_valid = !req_deep || IMPL_STATES[req_arg];
	wire logic in_run = is_running(state);
	wire logic hard_reset_wake = WAKE_EVENTS.soft_reset || WAKE_EVENTS.mcheck;
	assign soft_req_wake = wake;

	// wake sources filtered against the task priority mask
	wake_filter u_wake (
		.events (WAKE_EVENTS),
		.tpr    (tpr),
		.wake   (wake)
	);

	// interval timer runs on every edge regardless of state
	free_counter u_itc (
		.clk      (REF_CLK),
		.rstn     (RSTN),
		.count_en (1'b1),
		.value    (itc_value)
	);

	// cycle event frozen in any stop state
	free_counter u_cycles (
		.clk      (REF_CLK),
		.rstn     (RSTN),
		.count_en (in_run),
		.value    (cycle_value)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_state    = state;
		next_deep_arg = deep_arg;
		unique case (state)
			ST_NORMAL, ST_LOWPWR: begin
				// low-power only changes clocking, never event handling
				next_state = (lp_enable && LP_SUPPORTED) ? ST_LOWPWR : ST_NORMAL;
				if (wr_req && req_valid) begin
					if (!req_deep) begin
						next_state = ST_SHALLOW;
					end else if (req_arg == 3'h0) begin
						next_state = ST_SHALLOW;
					end else if (req_arg == 3'h1) begin
						next_state = ST_DEEP1;
					end else begin
						next_state    = ST_DEEPN;
						next_deep_arg = req_arg;
					end
				end
			end
			ST_SHALLOW, ST_DEEP1, ST_DEEPN: begin
				if (soft_req_wake || hard_reset_wake) begin
					next_state = ST_NORMAL;
				end
			end
			default: next_state = ST_NORMAL;
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state    <= ST_NORMAL;
			deep_arg <= 3'h0;
		end else begin
			state    <= next_state;
			deep_arg <= next_deep_arg;
		end
	end

	// software control; a bad request flags sticky error until next request
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lp_enable <= CTRL_RESET[CTRL_LP_EN_BIT];
			tpr       <= TPR_RESET;
			req_error <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				lp_enable <= REG_REQ.wdata[CTRL_LP_EN_BIT] & LP_SUPPORTED;
			end
			if (wr_tpr) begin
				tpr <= REG_REQ.wdata[7:0];
			end
			if (wr_req) begin
				req_error <= !req_valid;
			end
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (REG_REQ.addr)
			ADDR_CTRL:    rdata[CTRL_LP_EN_BIT] = lp_enable;
			ADDR_FEATURE: rdata[FEAT_LP_SUP_BIT] = LP_SUPPORTED;
			ADDR_REQUEST: rdata[2:0] = deep_arg;
			ADDR_STATUS: begin
				rdata[ST_ERR_BIT] = req_error;
				rdata[2:0]        = state;
			end
			ADDR_INFO:    rdata = {COHERENCY_INFO, 8'h00, IMPL_STATES};
			ADDR_ITC:     rdata = itc_value;
			ADDR_CYCLES:  rdata = cycle_value;
			ADDR_TPR:     rdata[7:0] = tpr;
			default:      rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// outputs, all registered
	// ****************************************
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA        <= 32'h0000_0000;
			SNOOP_ACK        <= 1'b0;
			CORE_RUN         <= 1'b1;
			LOW_POWER_ACTIVE <= 1'b0;
			STATE            <= 3'h0;
		end else begin
			REG_RDATA        <= REG_REQ.rd ? rdata : 32'h0000_0000;
			// deep stop 1 drops snoops; others answer them
			SNOOP_ACK        <= SNOOP_REQ && (state != ST_DEEP1);
			CORE_RUN         <= is_running(next_state);
			LOW_POWER_ACTIVE <= (next_state == ST_LOWPWR);
			STATE            <= next_state;
		end
	end

endmodule

// *** testbench/pwr_seq_asserts.sv ***
`timescale 1ns/100ps
module pwr_seq_asserts (
	input wire logic                 REF_CLK,
	input wire logic                 RSTN,
	input wire pwr_seq_pkg::regreq_t REG_REQ,
	input wire logic [31:0]          REG_RDATA,
	input wire pwr_seq_pkg::wake_t   WAKE_EVENTS,
	input wire logic                 SNOOP_REQ,
	input wire logic                 SNOOP_ACK,
	input wire logic                 CORE_RUN,
	input wire logic                 LOW_POWER_ACTIVE,
	input wire logic [2:0]           STATE
);
	import pwr_seq_pkg::*;
	// ****************************************
	// state, snoop and read data checks
	// ****************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// a quiet request, so no wake source can race the entry
	sequence shallow_req;
		REG_REQ.wr && REG_REQ.addr == ADDR_REQUEST && REG_REQ.wdata[3:0] == 4'h0
			&& CORE_RUN && WAKE_EVENTS == '0;
	endsequence
	sequence hard_wake;
		STATE == ST_SHALLOW && (WAKE_EVENTS.nmi || WAKE_EVENTS.mcheck
			|| WAKE_EVENTS.soft_reset || WAKE_EVENTS.platform_mgmt_interrupt || WAKE_EVENTS.init);
	endsequence
	shallow_entry_a: assert property (shallow_req |=> STATE == ST_SHALLOW && !CORE_RUN)
		else $error("shallow stop not entered");
	wake_exit_a: assert property (hard_wake |-> ##[1:2] CORE_RUN)
		else $error("wake event did not restart the core");
	snoop_ack_a: assert property (SNOOP_REQ && STATE != ST_DEEP1 |=> SNOOP_ACK)
		else $error("snoop not answered");
	deep_nosnoop_a: assert property (STATE == ST_DEEP1 |=> !SNOOP_ACK)
		else $error("snoop answered in deep stop one");
	run_flag_a: assert property (CORE_RUN == (STATE == ST_NORMAL || STATE == ST_LOWPWR))
		else $error("core run flag disagrees with state");
	lp_flag_a: assert property (LOW_POWER_ACTIVE == (STATE == ST_LOWPWR))
		else $error("low power flag disagrees with state");
	rdata_idle_a: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == 32'h0000_0000)
		else $error("read data outside read slot");
	feature_rd_a: assert property ($past(REG_REQ.rd) && $past(REG_REQ.addr) == ADDR_FEATURE
		|-> REG_RDATA[FEAT_LP_SUP_BIT] == LP_SUPPORTED)
		else $error("feature bit wrong");
	bad_req_a: assert property (REG_REQ.wr && REG_REQ.addr == ADDR_REQUEST && REG_REQ.wdata[3]
		&& !IMPL_STATES[REG_REQ.wdata[2:0]] && CORE_RUN && WAKE_EVENTS == '0 |=> CORE_RUN)
		else $error("absent state request stopped the core");
endmodule

// *** testbench/snoop_agent.sv ***
`timescale 1ns/100ps
module snoop_agent (
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  snoop_ack,
	output logic       snoop_req,
	output logic [15:0] acks
);
	logic [1:0] phase;
	// bus traffic never pauses for the core's stop states; in deep stop one the
	// requester owns coherency, so unanswered snoops are expected there
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= 2'h0;
			snoop_req <= 1'b0;
			acks <= 16'h0000;
		end else begin
			phase <= phase + 2'h1;
			snoop_req <= (phase == 2'h0);
			acks <= acks + 16'(snoop_ack);
		end
	end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import pwr_seq_pkg::*;
	logic REF_CLK = 1'b0;
	logic RSTN = 1'b0;
	regreq_t REG_REQ = '0;
	wake_t WAKE_EVENTS = '0;
	logic [31:0] REG_RDATA, e, m;
	logic [31:0] tick = 32'h0000_0000, held;
	logic SNOOP_REQ, SNOOP_ACK, CORE_RUN, LOW_POWER_ACTIVE, rd_d = 1'b0;
	logic [2:0] STATE;
	logic [15:0] acks;
	logic [3:0] cls;
	logic [31:0] exp_q[$], msk_q[$];
	int fail_count = 0, n_checks = 0, seed = 60382;
	// ****************************************
	// harness
	// ****************************************
	always #4 REF_CLK = ~REF_CLK;
	power_state_sequencer power_state_sequencer_inst (.REF_CLK(REF_CLK), .RSTN(RSTN),
		.REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .WAKE_EVENTS(WAKE_EVENTS),
		.SNOOP_REQ(SNOOP_REQ), .SNOOP_ACK(SNOOP_ACK), .CORE_RUN(CORE_RUN),
		.LOW_POWER_ACTIVE(LOW_POWER_ACTIVE), .STATE(STATE));
	snoop_agent snoop_agent_inst (.clk(REF_CLK), .rstn(RSTN), .snoop_ack(SNOOP_ACK),
		.snoop_req(SNOOP_REQ), .acks(acks));
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task print_verdict;
		if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge REF_CLK) REG_REQ <= '{a, d, 1'b1, 1'b0};
		@(posedge REF_CLK) REG_REQ <= '0;
	endtask
	// the note goes on the queue before the strobe, so the monitor never runs dry
	task rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] mk);
		exp_q.push_back(x & mk);
		msk_q.push_back(mk);
		@(posedge REF_CLK) REG_REQ <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge REF_CLK) REG_REQ <= '0;
	endtask
	task wake(input wake_t w);
		@(posedge REF_CLK) WAKE_EVENTS <= w;
		repeat (2) @(posedge REF_CLK);
		WAKE_EVENTS <= '0;
		repeat (2) @(posedge REF_CLK);
	endtask
	function logic [31:0] st(input logic [2:0] s, input logic err);
		return {23'h0, err, 5'h00, s};
	endfunction
	// read data stand only in the cycle after the strobe: sample mid-cycle
	always @(posedge REF_CLK) rd_d <= REG_REQ.rd;
	// bench's own count of edges since reset release, the timer reference
	always @(posedge REF_CLK) tick <= RSTN ? tick + 32'h0000_0001 : 32'h0000_0000;
	always @(negedge REF_CLK) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			check("rdata", REG_RDATA & m, e);
		end
	end
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (8) @(posedge REF_CLK);
		RSTN <= 1'b1;
		rd(ADDR_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
		rd(ADDR_TPR, {24'h0, TPR_RESET}, 32'h0000_00FF);
		rd(ADDR_FEATURE, 32'(LP_SUPPORTED), 32'h0000_0001);
		rd(4'h8, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(ADDR_INFO, {COHERENCY_INFO, 8'h00, IMPL_STATES}, 32'hFFFF_00FF);
		// a read issued at an edge returns the count two edges further on
		rd(ADDR_ITC, tick + 32'h0000_0002, 32'hFFFF_FFFF);
		rd(ADDR_CYCLES, tick + 32'h0000_0002, 32'hFFFF_FFFF);
		wr(ADDR_CTRL, 32'h0000_0001);
		rd(ADDR_STATUS, st(ST_LOWPWR, 1'b0), 32'h0000_0107);
		wr(ADDR_CTRL, 32'h0000_0000);
		rd(ADDR_STATUS, st(ST_NORMAL, 1'b0), 32'h0000_0107);
		wr(ADDR_REQUEST, 32'h0000_0000);
		// the strobe edge itself still counts as running, then the event freezes
		held = tick + 32'h0000_0001;
		wr(ADDR_TPR, 32'h0000_0010);
		wake('{1'b1, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		rd(ADDR_STATUS, st(ST_SHALLOW, 1'b0), 32'h0000_0107);
		rd(ADDR_CYCLES, held, 32'hFFFF_FFFF);
		rd(ADDR_ITC, tick + 32'h0000_0002, 32'hFFFF_FFFF);
		wr(ADDR_TPR, 32'h0000_0009);
		cls = 4'($unsigned($random(seed)) % 10);
		wake('{1'b1, cls, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		rd(ADDR_STATUS, st(ST_SHALLOW, 1'b0), 32'h0000_0107);
		wake('{1'b1, 4'hA, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
		rd(ADDR_STATUS, st(ST_NORMAL, 1'b0), 32'h0000_0107);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_REQUEST, 32'h0000_0000);
			wake(wake_t'(10'(1 << i)));
			rd(ADDR_STATUS, st(ST_NORMAL, 1'b0), 32'h0000_0107);
		end
		// deep arguments 1 to 7; absent states must bounce with the error bit
		for (int a = 1; a < 8; a++) begin
			wr(ADDR_REQUEST, 32'(8 + a));
			rd(ADDR_STATUS, st((a == 1) ? ST_DEEP1 : (IMPL_STATES[a] ? ST_DEEPN : ST_NORMAL),
				!IMPL_STATES[a]), 32'h0000_0107);
			wake('{1'b0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1});
		end
		repeat (2) @(posedge REF_CLK);
		check("snoop acks", 32'(acks != 16'h0000), 32'h0000_0001);
		print_verdict();
	end
endmodule
bind power_state_sequencer pwr_seq_asserts pwr_seq_asserts_inst (.REF_CLK(REF_CLK),
	.RSTN(RSTN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .WAKE_EVENTS(WAKE_EVENTS),
	.SNOOP_REQ(SNOOP_REQ), .SNOOP_ACK(SNOOP_ACK), .CORE_RUN(CORE_RUN),
	.LOW_POWER_ACTIVE(LOW_POWER_ACTIVE), .STATE(STATE));
